// [inc/fvr_pkg.sv]
// Behaviour
// - Record L1 current on any overcurrent start/operate
// - New record shifts history, oldest entry dropped
// - Newest in main, four older in subregisters
// - Start without operate keeps peak L1 current
// - Operate stores current at operate instant
// - L2 and L3 stacks at addresses 2, 3
// - Register 4 holds low-set start duration percent
// - Low-set start pushes new duration entry
// - Operated stage duration reads exactly 100
// - Low-set starts counted in subregister 5
// - Register 5 holds high-set duration, same rules
// - High-set starts counted in own subregister 5
// - Register 6 records residual current, five deep
// - Residual peak on start, instant value on operate
// - Display shows address digit and value digits
// - Full reset clears every recorded register
package fvr_pkg;

  localparam int VAL_W = 10;          // Three decimal digits, 0..999
  localparam int DEPTH = 5;           // Main register plus four subregisters
  localparam int CNT_W = 8;
  localparam int ADDR_W = 4;
  localparam int SUB_W = 3;

  localparam logic [CNT_W-1:0]  CNT_MAX     = 8'hff;
  localparam logic [CNT_W-1:0]  CNT_ONE     = 8'h01;
  localparam logic [VAL_W-1:0]  PCT_OPERATE = 10'h064;  // 100 percent

  // Display register addresses
  localparam logic [ADDR_W-1:0] ADDR_L1   = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_L2   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_L3   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_LOW  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_HIGH = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_RES  = 4'h6;

  // Subregister 5 holds the start counter
  localparam logic [SUB_W-1:0]  SUB_COUNT = 3'h5;

  // Stage index within the overcurrent group
  localparam int IDX_LOW  = 0;
  localparam int IDX_HIGH = 1;

  typedef struct packed {
    logic [2:0] oc_start;   // Low, high, instantaneous overcurrent
    logic [2:0] oc_oper;
    logic [1:0] ef_start;   // low_set_earth_fault_stage, high_set_...
    logic [1:0] ef_oper;
  } stage_bus_type;

  typedef struct packed {
    logic [VAL_W-1:0] il1;
    logic [VAL_W-1:0] il2;
    logic [VAL_W-1:0] il3;
    logic [VAL_W-1:0] i0;
  } currents_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [VAL_W-1:0]  value;
  } display_type;

endpackage

// [verilog/fault_value_recorder.sv]
`timescale 1ns/1ps
`default_nettype none

// One five-deep history with peak tracking and operate capture
module fault_stack #(
  parameter int W     = 10,
  parameter int DEPTH = 5
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  input  wire logic                  clear,
  input  wire logic                  active,
  input  wire logic                  operate,
  input  wire logic [W-1:0]          sample,
  input  wire logic [W-1:0]          op_sample,
  output logic      [DEPTH-1:0][W-1:0] entries
);

  logic [DEPTH-1:0][W-1:0] entries_reg;
  logic [DEPTH-1:0][W-1:0] entries_next;
  logic                    active_reg;
  logic                    active_next;
  logic                    frozen_reg;
  logic                    frozen_next;

  // Next state of the history
  always_comb begin
    entries_next = entries_reg;
    frozen_next  = frozen_reg;
    active_next  = active;
    if (clear) begin
      entries_next = '0;
      frozen_next  = 1'b0;
      active_next  = 1'b0;
    end else if (active && !active_reg) begin
      // New fault: shift deeper, oldest falls off
      entries_next[DEPTH-1:1] = entries_reg[DEPTH-2:0];
      entries_next[0] = operate ? op_sample : sample;
      frozen_next = operate;
    end else if (active && operate && !frozen_reg) begin
      entries_next[0] = op_sample;
      frozen_next = 1'b1;
    end else if (active && !frozen_reg && sample > entries_reg[0]) begin
      entries_next[0] = sample;
    end
    if (!active) begin
      frozen_next = 1'b0;
    end
  end

  // Register the history
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      entries_reg <= '0;
      active_reg  <= 1'b0;
      frozen_reg  <= 1'b0;
    end else begin
      entries_reg <= entries_next;
      active_reg  <= active_next;
      frozen_reg  <= frozen_next;
    end
  end

  assign entries = entries_reg;

  a_push_shift: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (!clear && active && !active_reg)
      |=> (entries_reg[1] == $past(entries_reg[0])) &&
          (entries_reg[DEPTH-1] == $past(entries_reg[DEPTH-2])))
    else $error("history did not shift on new fault");
  a_operate_capture: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (!clear && active && operate && !frozen_reg)
      |=> entries_reg[0] == $past(op_sample))
    else $error("operate value not captured");
  a_peak_track: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (!clear && active && active_reg && !frozen_reg && !operate)
      |=> (entries_reg[0] >= $past(sample)) &&
          (entries_reg[0] >= $past(entries_reg[0])))
    else $error("peak value not held during start");
  a_single_entry: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (!clear && active && active_reg)
      |=> entries_reg[1] == $past(entries_reg[1]))
    else $error("extra entry pushed within one fault");
  a_frozen_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (!clear && frozen_reg && active && active_reg)
      |=> entries_reg[0] == $past(entries_reg[0]))
    else $error("operate value overwritten after operation");
  a_clear_all: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    clear |=> entries_reg == '0)
    else $error("history not cleared");

endmodule // fault_stack

// Fault recorder: current and duration histories, counters, display
module fault_value_recorder #(
  parameter int VAL_W = fvr_pkg::VAL_W,
  parameter int DEPTH = fvr_pkg::DEPTH,
  parameter int CNT_W = fvr_pkg::CNT_W
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  input  wire fvr_pkg::stage_bus_type        stages,
  input  wire fvr_pkg::currents_type         currents,
  input  wire logic [VAL_W-1:0]              low_dur_pct,
  input  wire logic [VAL_W-1:0]              high_dur_pct,
  input  wire logic                          reset_ctrl_pin,
  input  wire logic                          full_reset_select_switch,
  input  wire logic [fvr_pkg::ADDR_W-1:0]    disp_addr_sel,
  input  wire logic [fvr_pkg::SUB_W-1:0]     disp_sub_sel,
  output fvr_pkg::display_type               display,
  output logic                               records_cleared
);

  // Pin synchroniser for the external reset control
  logic reset_meta_reg;
  logic reset_sync_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_meta_reg <= 1'b0;
      reset_sync_reg <= 1'b0;
    end else begin
      reset_meta_reg <= reset_ctrl_pin;
      reset_sync_reg <= reset_meta_reg;
    end
  end

  logic clear;
  assign clear = reset_sync_reg & full_reset_select_switch;

  // Group activity of the stage families
  logic oc_active;
  logic oc_oper;
  logic ef_active;
  logic ef_oper;
  logic low_active;
  logic high_active;

  assign oc_active   = |stages.oc_start | |stages.oc_oper;
  assign oc_oper     = |stages.oc_oper;
  assign ef_active   = |stages.ef_start | |stages.ef_oper;
  assign ef_oper     = |stages.ef_oper;
  assign low_active  = stages.oc_start[fvr_pkg::IDX_LOW] |
                       stages.oc_oper[fvr_pkg::IDX_LOW];
  assign high_active = stages.oc_start[fvr_pkg::IDX_HIGH] |
                       stages.oc_oper[fvr_pkg::IDX_HIGH];

  logic [DEPTH-1:0][VAL_W-1:0] l1_hist;
  logic [DEPTH-1:0][VAL_W-1:0] l2_hist;
  logic [DEPTH-1:0][VAL_W-1:0] l3_hist;
  logic [DEPTH-1:0][VAL_W-1:0] low_hist;
  logic [DEPTH-1:0][VAL_W-1:0] high_hist;
  logic [DEPTH-1:0][VAL_W-1:0] res_hist;

  // Phase current histories, one per phase
  fault_stack #(.W(VAL_W), .DEPTH(DEPTH)) l1_stack (
    .ref_clk   (ref_clk), .rst_b (rst_b),
    .clear     (clear),
    .active    (oc_active),
    .operate   (oc_oper),
    .sample    (currents.il1),
    .op_sample (currents.il1),
    .entries   (l1_hist)
  );

  fault_stack #(.W(VAL_W), .DEPTH(DEPTH)) l2_stack (
    .ref_clk   (ref_clk), .rst_b (rst_b),
    .clear     (clear),
    .active    (oc_active),
    .operate   (oc_oper),
    .sample    (currents.il2),
    .op_sample (currents.il2),
    .entries   (l2_hist)
  );

  fault_stack #(.W(VAL_W), .DEPTH(DEPTH)) l3_stack (
    .ref_clk   (ref_clk), .rst_b (rst_b),
    .clear     (clear),
    .active    (oc_active),
    .operate   (oc_oper),
    .sample    (currents.il3),
    .op_sample (currents.il3),
    .entries   (l3_hist)
  );

  // Start durations; operation pins the entry at 100 percent
  fault_stack #(.W(VAL_W), .DEPTH(DEPTH)) low_stack (
    .ref_clk   (ref_clk), .rst_b (rst_b),
    .clear     (clear),
    .active    (low_active),
    .operate   (stages.oc_oper[fvr_pkg::IDX_LOW]),
    .sample    (low_dur_pct),
    .op_sample (fvr_pkg::PCT_OPERATE),
    .entries   (low_hist)
  );

  fault_stack #(.W(VAL_W), .DEPTH(DEPTH)) high_stack (
    .ref_clk   (ref_clk), .rst_b (rst_b),
    .clear     (clear),
    .active    (high_active),
    .operate   (stages.oc_oper[fvr_pkg::IDX_HIGH]),
    .sample    (high_dur_pct),
    .op_sample (fvr_pkg::PCT_OPERATE),
    .entries   (high_hist)
  );

  // Residual current history
  fault_stack #(.W(VAL_W), .DEPTH(DEPTH)) res_stack (
    .ref_clk   (ref_clk), .rst_b (rst_b),
    .clear     (clear),
    .active    (ef_active),
    .operate   (ef_oper),
    .sample    (currents.i0),
    .op_sample (currents.i0),
    .entries   (res_hist)
  );

  // Start counters with edge detection
  logic             low_prev_reg;
  logic             low_prev_next;
  logic             high_prev_reg;
  logic             high_prev_next;
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] low_cnt_next;
  logic [CNT_W-1:0] high_cnt_reg;
  logic [CNT_W-1:0] high_cnt_next;
  logic             low_edge;
  logic             high_edge;

  assign low_edge  = low_active & ~low_prev_reg;
  assign high_edge = high_active & ~high_prev_reg;

  always_comb begin
    low_prev_next  = low_active;
    high_prev_next = high_active;
    low_cnt_next   = low_cnt_reg;
    high_cnt_next  = high_cnt_reg;
    if (clear) begin
      low_cnt_next   = '0;
      high_cnt_next  = '0;
      low_prev_next  = 1'b0;
      high_prev_next = 1'b0;
    end else begin
      if (low_edge && low_cnt_reg != fvr_pkg::CNT_MAX) begin
        low_cnt_next = low_cnt_reg + fvr_pkg::CNT_ONE;
      end
      if (high_edge && high_cnt_reg != fvr_pkg::CNT_MAX) begin
        high_cnt_next = high_cnt_reg + fvr_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_prev_reg  <= 1'b0;
      high_prev_reg <= 1'b0;
      low_cnt_reg   <= '0;
      high_cnt_reg  <= '0;
    end else begin
      low_prev_reg  <= low_prev_next;
      high_prev_reg <= high_prev_next;
      low_cnt_reg   <= low_cnt_next;
      high_cnt_reg  <= high_cnt_next;
    end
  end

  a_count_step: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (!clear && low_edge && low_cnt_reg != fvr_pkg::CNT_MAX)
      |=> low_cnt_reg == $past(low_cnt_reg) + fvr_pkg::CNT_ONE)
    else $error("low-set start not counted");
  a_count_saturate: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !clear |=> (low_cnt_reg >= $past(low_cnt_reg)) &&
               (high_cnt_reg >= $past(high_cnt_reg)))
    else $error("start counter wrapped");

  // Display selection: address digit plus value digits
  fvr_pkg::display_type display_reg;
  fvr_pkg::display_type display_next;
  logic                 cleared_reg;
  logic                 cleared_next;
  logic                 sub_ok;
  logic                 sub_cnt;

  assign sub_ok  = disp_sub_sel < fvr_pkg::SUB_W'(DEPTH);
  assign sub_cnt = disp_sub_sel == fvr_pkg::SUB_COUNT;

  always_comb begin
    display_next.addr  = disp_addr_sel;
    display_next.value = '0;
    cleared_next       = clear;
    if (sub_ok) begin
      unique case (disp_addr_sel)
        fvr_pkg::ADDR_L1:   display_next.value = l1_hist[disp_sub_sel];
        fvr_pkg::ADDR_L2:   display_next.value = l2_hist[disp_sub_sel];
        fvr_pkg::ADDR_L3:   display_next.value = l3_hist[disp_sub_sel];
        fvr_pkg::ADDR_LOW:  display_next.value = low_hist[disp_sub_sel];
        fvr_pkg::ADDR_HIGH: display_next.value = high_hist[disp_sub_sel];
        fvr_pkg::ADDR_RES:  display_next.value = res_hist[disp_sub_sel];
        default:            display_next.value = '0;
      endcase
    end else if (sub_cnt && disp_addr_sel == fvr_pkg::ADDR_LOW) begin
      display_next.value = VAL_W'(low_cnt_reg);
    end else if (sub_cnt && disp_addr_sel == fvr_pkg::ADDR_HIGH) begin
      display_next.value = VAL_W'(high_cnt_reg);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      display_reg <= '0;
      cleared_reg <= 1'b0;
    end else begin
      display_reg <= display_next;
      cleared_reg <= cleared_next;
    end
  end

  assign display         = display_reg;
  assign records_cleared = cleared_reg;

  a_display_addr: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    1'b1 |=> display_reg.addr == $past(disp_addr_sel))
    else $error("display address digit wrong");
  a_full_reset: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    clear |=> (low_cnt_reg == '0) && (high_cnt_reg == '0) && cleared_reg)
    else $error("counters not cleared by full reset");

endmodule // fault_value_recorder

`default_nettype wire

// [bench/fault_source_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Stage logic and current front end, one fault frame per request
module fault_source_model (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              go,
  input  wire logic [2:0]        grp,
  input  wire logic [2:0]        op_cyc,
  input  wire logic [39:0]       vals,
  output fvr_pkg::stage_bus_type stages,
  output fvr_pkg::currents_type  currents,
  output logic      [9:0]        low_dur_pct,
  output logic      [9:0]        high_dur_pct,
  output logic                   busy
);
  logic [2:0] k;
  logic [9:0] idle;
  logic [9:0] v;
  logic       act;

  // Frame: four active cycles, two idle; idle pattern keeps moving
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      k <= 3'h0;
      idle <= 10'h000;
    end else begin
      idle <= idle + 10'h007;
      if (go && !busy) begin
        busy <= 1'b1;
        k <= 3'h0;
      end else if (busy) begin
        k <= k + 3'h1;
        if (k == 3'h5) begin
          busy <= 1'b0;
        end
      end
    end
  end

  // Start held for the four active cycles, operate from op_cyc on; no operate if 4
  always_comb begin
    act = busy && (k < 3'h4);
    v = act ? vals[k*10 +: 10] : ~idle;
    stages = '0;
    if (act && grp < 3'h3) begin
      stages.oc_start[grp] = 1'b1;
      stages.oc_oper[grp] = (k >= op_cyc);
    end else if (act) begin
      stages.ef_start[grp - 3'h3] = 1'b1;
      stages.ef_oper[grp - 3'h3] = (k >= op_cyc);
    end
    currents = {v, v + 10'h001, v + 10'h002, v + 10'h003};
    low_dur_pct = act ? {7'h0, k} * 10'h014 + {6'h0, vals[3:0]} : ~idle;
    high_dur_pct = low_dur_pct;
  end
endmodule // fault_source_model

`default_nettype wire

// [bench/test_fault_value_recorder.sv]
`timescale 1ns/1ps
`default_nettype none

module test_fault_value_recorder;
  logic                  ref_clk;
  logic                  rst_b;
  logic                  go;
  logic                  busy;
  logic [2:0]            grp;
  logic [2:0]            op_cyc;
  logic [39:0]           vals;
  fvr_pkg::stage_bus_type stages;
  fvr_pkg::currents_type currents;
  logic [9:0]            low_dur_pct;
  logic [9:0]            high_dur_pct;
  logic                  reset_ctrl_pin;
  logic                  full_reset_select_switch;
  logic [3:0]            disp_addr_sel;
  logic [2:0]            disp_sub_sel;
  fvr_pkg::display_type  display;
  logic                  records_cleared;
  logic                  sel_valid;
  logic                  sel_seen = 1'b0;
  logic [31:0]           seed;
  logic [9:0]            stk [6][5];
  logic [7:0]            cnt [2];
  logic [13:0]           exp_q [$];
  int                    failures;
  int                    num_checks;
  int                    n;

  fault_source_model u_src (.ref_clk(ref_clk), .rst_b(rst_b), .go(go),
    .grp(grp), .op_cyc(op_cyc), .vals(vals), .stages(stages),
    .currents(currents), .low_dur_pct(low_dur_pct),
    .high_dur_pct(high_dur_pct), .busy(busy));

  fault_value_recorder u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .stages(stages), .currents(currents), .low_dur_pct(low_dur_pct),
    .high_dur_pct(high_dur_pct), .reset_ctrl_pin(reset_ctrl_pin),
    .full_reset_select_switch(full_reset_select_switch),
    .disp_addr_sel(disp_addr_sel), .disp_sub_sel(disp_sub_sel),
    .display(display), .records_cleared(records_cleared));

  // Xorshift source
  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Select one register and note what it should show
  task automatic expect_reg(input logic [3:0] a, input logic [2:0] s,
                            input logic [9:0] v);
    @(posedge ref_clk);
    disp_addr_sel <= a;
    disp_sub_sel <= s;
    sel_valid <= 1'b1;
    exp_q.push_back({a, v});
  endtask

  task automatic check_all();
    for (int a = 1; a < 7; a++) begin
      for (int s = 0; s < 5; s++) begin
        expect_reg(4'(a), 3'(s), stk[a-1][s]);
      end
    end
    expect_reg(4'h4, 3'h5, {2'h0, cnt[0]});
    expect_reg(4'h5, 3'h5, {2'h0, cnt[1]});
    expect_reg(4'h1, 3'h5, 10'h000);
    expect_reg(4'h7, 3'h0, 10'h000);
    expect_reg(4'h6, 3'h6, 10'h000);
    @(posedge ref_clk);
    sel_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic push(input int idx, input logic [9:0] v);
    for (int j = 4; j > 0; j--) begin
      stk[idx][j] = stk[idx][j-1];
    end
    stk[idx][0] = v;
  endtask

  // One fault of group g, operate at frame cycle oc (4 means none)
  task automatic fault(input logic [2:0] g, input logic [2:0] oc);
    logic [9:0] vv [4];
    logic [9:0] mx;
    logic [9:0] cur;
    int w;
    mx = 10'h000;
    for (int i = 0; i < 4; i++) begin
      vv[i] = 10'(nxt() % 990);
      if (vv[i] > mx) begin
        mx = vv[i];
      end
    end
    cur = (oc < 3'h4) ? vv[oc[1:0]] : mx;
    @(posedge ref_clk);
    go <= 1'b1;
    grp <= g;
    op_cyc <= oc;
    vals <= {vv[3], vv[2], vv[1], vv[0]};
    @(posedge ref_clk);
    go <= 1'b0;
    w = 0;
    do begin
      @(posedge ref_clk);
      w++;
    end while (busy && w < 20);
    if (g < 3'h3) begin
      for (int p = 0; p < 3; p++) begin
        push(p, cur + 10'(p));
      end
    end else begin
      push(5, cur + 10'h003);
    end
    if (g < 3'h2) begin
      push(3 + int'(g), (oc < 3'h4) ? 10'h064 : 10'h03c + vv[0][3:0]);
      if (cnt[g[0]] != 8'hff) begin
        cnt[g[0]]++;
      end
    end
  endtask

  // Compare display two edges after each selection
  always @(posedge ref_clk) begin
    if (sel_seen) begin
      check("display", {2'h0, display}, {2'h0, exp_q.pop_front()});
    end
    sel_seen <= sel_valid;
  end

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    results();
  end

  initial begin
    rst_b = 1'b0;
    go = 1'b0;
    grp = 3'h0;
    op_cyc = 3'h4;
    vals = 40'h0;
    reset_ctrl_pin = 1'b0;
    full_reset_select_switch = 1'b0;
    disp_addr_sel = 4'h1;
    disp_sub_sel = 3'h0;
    sel_valid = 1'b0;
    seed = 32'ha901;
    failures = 0;
    num_checks = 0;
    stk = '{default: '{default: 10'h000}};
    cnt = '{default: 8'h00};
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    check_all();
    // Every group, operate never, at first edge, in mid-start
    for (int g = 0; g < 5; g++) begin
      fault(3'(g), 3'h4);
      fault(3'(g), 3'h0);
      fault(3'(g), 3'h2);
      check_all();
    end
    // Low-set counter must stop at its maximum
    for (int i = 0; i < 260; i++) begin
      fault(3'h0, 3'(nxt() % 5));
    end
    fault(3'h1, 3'h1);
    check_all();
    // Pin alone must not clear
    @(posedge ref_clk);
    reset_ctrl_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check("records_cleared", {15'h0, records_cleared}, 16'h0000);
    check_all();
    @(posedge ref_clk);
    full_reset_select_switch <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (records_cleared !== 1'b1 && n < 6);
    check("records_cleared", {15'h0, records_cleared}, 16'h0001);
    reset_ctrl_pin <= 1'b0;
    full_reset_select_switch <= 1'b0;
    stk = '{default: '{default: 10'h000}};
    cnt = '{default: 8'h00};
    check_all();
    results();
  end
endmodule // test_fault_value_recorder

`default_nettype wire
